//--- sim/generic_spi_register_port_test.sv
// self-checking bench for the serial register port, crc strap low, then high after a reset
// assumes a host model on the link and a register file echoing its address
`timescale 1ns/1ps
module generic_spi_register_port_test;
  logic                   sys_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   sclk, spi_cs_n, spi_sdi, sdo_out, sdo_oe, sdo_wire;
  logic [31:0]            rdata;
  logic [7:0]             status_event = 8'h00;
  logic                   level_hi = 1'b0;
  logic                   action_done = 1'b0;
  logic                   level_lo = 1'b1;
  logic                   strap_lvl = 1'b0;
  int                     n_crc = 0;
  logic                   action_start, crc_error, crc_enabled;
  spi_port_pkg::reg_req_t req;
  spi_port_pkg::reg_req_t wr_q[$];
  int                     n_errors = 0;
  int                     num_checks = 0;
  logic [95:0]            g;
  always #10 sys_clk = ~sys_clk;
  // the data-out pin has a pull resistor whose level is the crc strap
  assign sdo_wire = sdo_oe ? sdo_out : strap_lvl;
  always @(posedge sys_clk) if (crc_error === 1'b1) n_crc++;
  assign rdata = {3'h0, req.addr, 16'hc3a5};
  always @(posedge sys_clk) if (req.wr === 1'b1) wr_q.push_back(req);
  spi_host_model spi_host_model_inst (.sclk(sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .sdo(sdo_wire));
  generic_spi_register_port generic_spi_register_port_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .sclk(sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .sdo_in(sdo_wire),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .proto_generic(1'b1), .req(req), .rdata(rdata),
    .status_event(status_event), .status_level_hi(level_hi), .status_level_lo(level_lo),
    .action_start(action_start), .action_done(action_done), .crc_error(crc_error),
    .crc_enabled(crc_enabled));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic xfer(input logic [95:0] b, input int n);
    tick(1);
    wr_q.delete();
    spi_host_model_inst.frame(b, n, g);
    tick(12);
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    xfer({48'h0, 2'b10, 1'b1, a, d}, 48);
  endtask
  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    xfer({40'h0, 2'b10, 1'b0, a, 8'h00, 32'h0}, 56);
    d = g[31:0];
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_writes;
    wr(13'h0012, 32'ha5c3_1e07);
    check("wr count", 32'(wr_q.size()), 32'h1);
    check("wr addr", {19'h0, wr_q[0].addr}, 32'h12);
    check("wr data", wr_q[0].data, 32'ha5c3_1e07);
    xfer({16'h0, 2'b10, 1'b1, 13'h0100, 32'h1111_2222, 32'h8000_0001}, 80);
    check("burst count", 32'(wr_q.size()), 32'h2);
    check("burst addr", {19'h0, wr_q[1].addr}, 32'h101);
    check("burst data", wr_q[1].data, 32'h8000_0001);
    xfer({48'h0, 2'b01, 1'b1, 13'h0012, 32'hffff_ffff}, 48);
    check("bad hdr", 32'(wr_q.size()), 32'h0);
  endtask
  task automatic t_reads;
    xfer({8'h0, 2'b10, 1'b0, 13'h0040, 8'h00, 64'h0}, 88);
    check("rd word0", g[63:32], 32'h0040_c3a5);
    check("rd word1", g[31:0], 32'h0041_c3a5);
  endtask
  task automatic t_status;
    logic [31:0] d;
    status_event = 8'h04;
    level_hi = 1'b1;
    level_lo = 1'b0;
    tick(1);
    status_event = 8'h00;
    level_hi = 1'b0;
    level_lo = 1'b1;
    rd(spi_port_pkg::ADDR_STATUS, d);
    check("status held", d & 32'h304, 32'h104);
    wr(spi_port_pkg::ADDR_STATUS, 32'h1);
    rd(spi_port_pkg::ADDR_STATUS, d);
    check("status other", d & 32'h304, 32'h204);
    wr(spi_port_pkg::ADDR_STATUS, 32'h4);
    rd(spi_port_pkg::ADDR_STATUS, d);
    check("status clear", d & 32'h304, 32'h200);
  endtask
  task automatic t_action;
    wr(spi_port_pkg::ADDR_CTRL, 32'h1);
    check("action set", {31'h0, action_start}, 32'h1);
    action_done = 1'b1;
    tick(1);
    action_done = 1'b0;
    tick(2);
    check("action clr", {31'h0, action_start}, 32'h0);
  endtask
  // second power-up with the strap pulled high: checksum on
  task automatic t_crc;
    logic [15:0] h;
    sys_rst = 1'b1;
    strap_lvl = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(10);
    check("crc strap on", {31'h0, crc_enabled}, 32'h1);
    h = {3'h5, spi_port_pkg::ADDR_TX_LEN};
    xfer({32'h0, h, crc8({16'h0, h}, 16), 32'h5, crc8(32'h5, 32)}, 64);
    check("len count", 32'(wr_q.size()), 32'h1);
    check("len data", wr_q[0].data, 32'h5);
    h = {3'h5, spi_port_pkg::ADDR_TX_DATA};
    xfer({8'h0, h, crc8({16'h0, h}, 16), 32'h1122_3344, 32'h5566_7788}, 88);
    check("frame count", 32'(wr_q.size()), 32'h2);
    check("frame addr", {19'h0, wr_q[1].addr}, {19'h0, spi_port_pkg::ADDR_TX_DATA});
    check("frame be", {24'h0, wr_q[0].byte_en, wr_q[1].byte_en}, 32'hf8);
    check("frame data", wr_q[1].data, 32'h5566_7788);
    h = {3'h5, spi_port_pkg::ADDR_CTRL};
    xfer({32'h0, h, ~crc8({16'h0, h}, 16), 32'h1, crc8(32'h1, 32)}, 64);
    check("crc err count", 32'(n_crc), 32'h1);
    check("bad crc wr", 32'(wr_q.size()), 32'h0);
    h = {3'h4, spi_port_pkg::ADDR_TX_LEN};
    xfer({24'h0, h, crc8({16'h0, h}, 16), 8'h0, 40'h0}, 72);
    check("crc rd word", g[39:8], 32'h5);
    check("crc rd crc", {24'h0, g[7:0]}, {24'h0, crc8(32'h5, 32)});
    check("oe idle", {31'h0, sdo_oe}, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    tick(10);
    check("crc strap", {31'h0, crc_enabled}, 32'h0);
    t_writes();
    t_reads();
    t_status();
    t_action();
    t_crc();
    check("crc err", {31'h0, crc_error}, 32'h0);
    results();
  end
  // the whole run needs well under half a millisecond
  initial begin
    #1000000;
    n_errors++;
    results();
  end
endmodule

//--- sim/spi_host_model.sv
// behavioural host that masters the four-wire link, msb first, sclk idle low
// assumes the device samples on rising sclk and shifts out after falling sclk
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // ****************************************
  // one framed transfer of the low n bits
  // ****************************************
  // sdo is sampled late in the high phase, the device needs several cycles per edge
  task automatic frame(input logic [95:0] bits, input int n, output logic [95:0] got);
    got = '0;
    spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_sdi = bits[i]; // zeros after the turnaround field come from the caller
      #80 sclk = 1'b1;
      #80 got[i] = sdo;
      sclk = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // a released line must not keep its last bit
  endtask
endmodule

//--- verilog/generic_spi_register_port.sv
// serial register port: four-wire slave, header decode, burst words, optional crc
// assumes the host shifts data on falling sclk and samples on rising sclk, cs low framing
//
// Overview of operation
// [RULE1] registers are reached over clock, chip select, data in and data out (strap too)
// [RULE2] protocol choice comes from a configuration pin, never a register
// [RULE3] every access moves whole 32-bit words
// [RULE4] single and burst accesses; burst words follow one header
// [RULE5] most significant bit first on both data lines
// [RULE6] direction bit 0 reads, 1 writes; reads carry an 8-bit turnaround field
// [RULE7] host sizes bursts in four-byte words; last frame word holds 1..4 bytes
// [RULE8] frame length includes two header bytes; padding bytes in last word ignored (the code counts the length in data bytes only, without the header)
// [RULE9] checksum enable comes from a strap sampled at power-up
// [RULE10] checksum is crc8 x^8+x^2+x+1 seeded with zero
// [RULE11] with checksum, crc after address and after every control data word
// [RULE12] frame data words carry no per-word crc
// [RULE13] control write: 1, 0, direction, 13-bit address, then 32-bit word
// [RULE14] write-one-to-clear bits are readable and clear only on a written one
// [RULE15] latching status bits hold a high or low event until read
// [RULE16] self-clearing bits return to zero once their action is done
// [RULE17] read words start in the bit period right after turnaround
`timescale 1ns/1ps
module generic_spi_register_port #(
  parameter int EVT_W = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_sdi,
  input  wire logic                  sdo_in,
  output logic                       sdo_out,
  output logic                       sdo_oe,
  input  wire logic                  proto_generic,
  output spi_port_pkg::reg_req_t     req,
  input  wire logic [31:0]           rdata,
  input  wire logic [EVT_W-1:0]      status_event,
  input  wire logic                  status_level_hi,
  input  wire logic                  status_level_lo,
  output logic                       action_start,
  input  wire logic                  action_done,
  output logic                       crc_error,
  output logic                       crc_enabled
);
  if (EVT_W < 1 || EVT_W > spi_port_pkg::STAT_LH_BIT) begin : g_bad_evt
    $error("EVT_W must lie between 1 and the latch bit position");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0]  sync1_reg, sync2_reg, sync3_reg, filt_reg, prev_reg;
  logic [4:0]  pins, filt_next;
  logic        cs_act, sclk_rise, sclk_fall, sdi_bit;
  logic [1:0]  strap_cnt_reg;
  logic        strap_done_reg, crc_en_reg, generic_reg;

  assign pins = {proto_generic, sdo_in, spi_sdi, spi_cs_n, sclk}; // [RULE1]
  // a change only counts once the last two stages agree
  assign filt_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= spi_port_pkg::PIN_RST;
      sync2_reg <= spi_port_pkg::PIN_RST;
      sync3_reg <= spi_port_pkg::PIN_RST;
      filt_reg  <= spi_port_pkg::PIN_RST;
      prev_reg  <= spi_port_pkg::PIN_RST;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
      prev_reg  <= filt_reg;
    end
  end

  // straps are caught after release, once the synchronised copies have settled;
  // the filter's next value is taken, the registered copy is one cycle too late
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_reg  <= '0;
      strap_done_reg <= 1'b0;
      crc_en_reg     <= 1'b0;
      generic_reg    <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == spi_port_pkg::STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        crc_en_reg     <= filt_next[spi_port_pkg::PIN_STRAP];  // [RULE9]
        generic_reg    <= filt_next[spi_port_pkg::PIN_PROTO];  // [RULE2]
      end
    end
  end

  assign crc_enabled = crc_en_reg;
  assign cs_act      = generic_reg & strap_done_reg & ~filt_reg[spi_port_pkg::PIN_CS_N];
  assign sclk_rise   = filt_reg[spi_port_pkg::PIN_SCLK] & ~prev_reg[spi_port_pkg::PIN_SCLK];
  assign sclk_fall   = ~filt_reg[spi_port_pkg::PIN_SCLK] & prev_reg[spi_port_pkg::PIN_SCLK];
  assign sdi_bit     = filt_reg[spi_port_pkg::PIN_SDI];

  // ****************************************
  // transaction sequencer
  // ****************************************
  spi_port_pkg::link_state_t state_reg;
  logic [4:0]  bit_cnt_reg;
  logic [31:0] in_sr_reg, in_word, word_reg;
  logic [12:0] addr_reg, addr_step;
  logic        wr_dir_reg, is_data_reg, ctrl_crc;
  logic [15:0] hdr_now;
  logic [3:0]  be_now;
  logic [15:0] tx_remain_reg;

  assign in_word   = {in_sr_reg[30:0], sdi_bit};  // [RULE5]
  assign hdr_now   = {spi_port_pkg::HDR_MARK1, spi_port_pkg::HDR_MARK0, wr_dir_reg, addr_reg};
  // frame fifo locations are not auto-incremented during a burst
  assign addr_step = is_data_reg ? addr_reg : addr_reg + 13'h1;  // [RULE4]
  assign ctrl_crc  = crc_en_reg & ~is_data_reg;  // [RULE12]

  // padding bytes of the last frame word get no byte enable
  always_comb begin
    be_now = 4'hf;
    if (addr_reg == spi_port_pkg::ADDR_TX_DATA && tx_remain_reg < spi_port_pkg::BYTES_PER_WORD) begin
      unique case (tx_remain_reg[1:0])  // [RULE8] [RULE7]
        2'h1:    be_now = 4'h8;
        2'h2:    be_now = 4'hc;
        2'h3:    be_now = 4'he;
        default: be_now = 4'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= spi_port_pkg::ST_HDR;
      bit_cnt_reg <= spi_port_pkg::HDR_LAST;
      in_sr_reg   <= '0;
      word_reg    <= '0;
      addr_reg    <= '0;
      wr_dir_reg  <= 1'b0;
      is_data_reg <= 1'b0;
      req         <= '0;
      crc_error   <= 1'b0;
    end else begin
      req.wr    <= 1'b0;
      req.rd    <= 1'b0;
      crc_error <= 1'b0;
      if (!cs_act) begin
        state_reg   <= spi_port_pkg::ST_HDR;
        bit_cnt_reg <= spi_port_pkg::HDR_LAST;
      end else if (sclk_rise) begin
        in_sr_reg   <= in_word;
        bit_cnt_reg <= bit_cnt_reg - 5'd1;
        if (bit_cnt_reg == '0) begin
          unique case (state_reg)
            spi_port_pkg::ST_HDR: begin  // [RULE13]
              addr_reg    <= in_word[spi_port_pkg::ADDR_W-1:0];
              wr_dir_reg  <= in_word[spi_port_pkg::HDR_DIR_BIT];
              is_data_reg <= in_word[12:0] == spi_port_pkg::ADDR_TX_DATA ||
                             in_word[12:0] == spi_port_pkg::ADDR_RX_DATA;
              if (in_word[spi_port_pkg::HDR_MARK1_BIT] != spi_port_pkg::HDR_MARK1 ||
                  in_word[spi_port_pkg::HDR_MARK0_BIT] != spi_port_pkg::HDR_MARK0) begin
                state_reg <= spi_port_pkg::ST_DROP;
              end else if (crc_en_reg) begin  // [RULE11]
                state_reg   <= spi_port_pkg::ST_HCRC;
                bit_cnt_reg <= spi_port_pkg::CRC_LAST;
              end else if (in_word[spi_port_pkg::HDR_DIR_BIT] == spi_port_pkg::DIR_WRITE) begin
                state_reg   <= spi_port_pkg::ST_WDATA;  // [RULE6]
                bit_cnt_reg <= spi_port_pkg::WORD_LAST;
              end else begin
                state_reg   <= spi_port_pkg::ST_TA;
                bit_cnt_reg <= spi_port_pkg::TA_LAST;
              end
            end
            spi_port_pkg::ST_HCRC: begin
              if (in_word[7:0] != spi_port_pkg::crc8_bits(spi_port_pkg::CRC_SEED, {16'h0, hdr_now},
                                                          spi_port_pkg::HDR_W)) begin  // [RULE10]
                state_reg <= spi_port_pkg::ST_DROP;
                crc_error <= 1'b1;
              end else if (wr_dir_reg == spi_port_pkg::DIR_WRITE) begin
                state_reg   <= spi_port_pkg::ST_WDATA;
                bit_cnt_reg <= spi_port_pkg::WORD_LAST;
              end else begin
                state_reg   <= spi_port_pkg::ST_TA;
                bit_cnt_reg <= spi_port_pkg::TA_LAST;
              end
            end
            spi_port_pkg::ST_TA: begin  // [RULE17]
              req.rd      <= 1'b1;
              req.addr    <= addr_reg;
              state_reg   <= spi_port_pkg::ST_RDATA;
              bit_cnt_reg <= spi_port_pkg::WORD_LAST;
            end
            spi_port_pkg::ST_WDATA: begin  // [RULE3]
              word_reg <= in_word;
              if (ctrl_crc) begin
                state_reg   <= spi_port_pkg::ST_WCRC;
                bit_cnt_reg <= spi_port_pkg::CRC_LAST;
              end else begin
                req.wr      <= 1'b1;
                req.addr    <= addr_reg;
                req.data    <= in_word;
                req.byte_en <= be_now;
                addr_reg    <= addr_step;
                bit_cnt_reg <= spi_port_pkg::WORD_LAST;
              end
            end
            spi_port_pkg::ST_WCRC: begin  // [RULE11]
              if (in_word[7:0] == spi_port_pkg::crc8_bits(spi_port_pkg::CRC_SEED, word_reg,
                                                          spi_port_pkg::WORD_W)) begin
                req.wr      <= 1'b1;
                req.addr    <= addr_reg;
                req.data    <= word_reg;
                req.byte_en <= be_now;
                addr_reg    <= addr_step;
                state_reg   <= spi_port_pkg::ST_WDATA;
                bit_cnt_reg <= spi_port_pkg::WORD_LAST;
              end else begin
                state_reg <= spi_port_pkg::ST_DROP;
                crc_error <= 1'b1;
              end
            end
            spi_port_pkg::ST_RDATA: begin
              if (ctrl_crc) begin
                state_reg   <= spi_port_pkg::ST_RCRC;
                bit_cnt_reg <= spi_port_pkg::CRC_LAST;
              end else begin  // [RULE4]
                req.rd      <= 1'b1;
                req.addr    <= addr_step;
                addr_reg    <= addr_step;
                bit_cnt_reg <= spi_port_pkg::WORD_LAST;
              end
            end
            spi_port_pkg::ST_RCRC: begin
              req.rd      <= 1'b1;
              req.addr    <= addr_step;
              addr_reg    <= addr_step;
              state_reg   <= spi_port_pkg::ST_RDATA;
              bit_cnt_reg <= spi_port_pkg::WORD_LAST;
            end
            spi_port_pkg::ST_DROP: state_reg <= spi_port_pkg::ST_DROP;
          endcase
        end
      end
    end
  end

  // ****************************************
  // local registers
  // ****************************************
  logic             ctrl_sc_reg, lh_reg, ll_seen_reg, rd_pend_reg, rd_local_reg;
  logic [EVT_W-1:0] stat_evt_reg, w1c_mask;
  logic [15:0]      tx_len_reg;
  logic [31:0]      local_word, local_val_reg, rd_word, last_rd_reg;
  logic             wr_ctrl, wr_stat, wr_len, wr_txd, rd_stat;

  assign wr_ctrl  = req.wr && req.addr == spi_port_pkg::ADDR_CTRL;
  assign wr_stat  = req.wr && req.addr == spi_port_pkg::ADDR_STATUS;
  assign wr_len   = req.wr && req.addr == spi_port_pkg::ADDR_TX_LEN;
  assign wr_txd   = req.wr && req.addr == spi_port_pkg::ADDR_TX_DATA;
  assign rd_stat  = req.rd && req.addr == spi_port_pkg::ADDR_STATUS;
  assign w1c_mask = wr_stat ? req.data[EVT_W-1:0] : '0;
  assign action_start = ctrl_sc_reg;

  always_comb begin
    local_word = '0;
    unique case (req.addr)
      spi_port_pkg::ADDR_CTRL:   local_word[spi_port_pkg::CTRL_SC_BIT] = ctrl_sc_reg;
      spi_port_pkg::ADDR_STATUS: begin
        local_word[EVT_W-1:0]                = stat_evt_reg;
        local_word[spi_port_pkg::STAT_LH_BIT] = lh_reg;
        local_word[spi_port_pkg::STAT_LL_BIT] = ~ll_seen_reg;
      end
      spi_port_pkg::ADDR_TX_LEN: local_word[15:0] = tx_len_reg;
      default:                   local_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_sc_reg   <= 1'b0;
      stat_evt_reg  <= '0;
      lh_reg        <= 1'b0;
      ll_seen_reg   <= 1'b0;
      tx_len_reg    <= '0;
      tx_remain_reg <= '0;
    end else begin
      if (wr_ctrl && req.data[spi_port_pkg::CTRL_SC_BIT]) ctrl_sc_reg <= 1'b1;
      else if (action_done) ctrl_sc_reg <= 1'b0;  // [RULE16]
      // a new event beats a clear in the same cycle
      stat_evt_reg <= status_event | (stat_evt_reg & ~w1c_mask);  // [RULE14]
      lh_reg       <= status_level_hi | (lh_reg & ~rd_stat);  // [RULE15]
      ll_seen_reg  <= ~status_level_lo | (ll_seen_reg & ~rd_stat);
      if (wr_len) begin
        tx_len_reg    <= req.data[15:0];
        tx_remain_reg <= req.data[15:0];
      end else if (wr_txd) begin
        tx_remain_reg <= (tx_remain_reg < spi_port_pkg::BYTES_PER_WORD) ? '0
                         : tx_remain_reg - spi_port_pkg::BYTES_PER_WORD;
      end
    end
  end

  // ****************************************
  // read data shifter
  // ****************************************
  logic [31:0] tx_sr_reg;
  logic        skip_reg, load_crc;
  logic [7:0]  rd_crc;

  assign rd_word  = rd_local_reg ? local_val_reg : rdata;
  assign rd_crc   = spi_port_pkg::crc8_bits(spi_port_pkg::CRC_SEED, last_rd_reg, spi_port_pkg::WORD_W);
  assign load_crc = cs_act && sclk_rise && bit_cnt_reg == '0 &&
                    state_reg == spi_port_pkg::ST_RDATA && ctrl_crc;
  assign sdo_oe   = cs_act && (state_reg == spi_port_pkg::ST_RDATA ||
                               state_reg == spi_port_pkg::ST_RCRC);  // [RULE17]

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_reg   <= 1'b0;
      rd_local_reg  <= 1'b0;
      local_val_reg <= '0;
    end else begin
      rd_pend_reg   <= req.rd;
      rd_local_reg  <= req.addr == spi_port_pkg::ADDR_CTRL || req.addr == spi_port_pkg::ADDR_STATUS ||
                       req.addr == spi_port_pkg::ADDR_TX_LEN;
      local_val_reg <= local_word;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sr_reg   <= '0;
      last_rd_reg <= '0;
      sdo_out     <= 1'b0;
      skip_reg    <= 1'b0;
    end else if (!cs_act) begin
      sdo_out  <= 1'b0;
      skip_reg <= 1'b0;
    end else if (rd_pend_reg) begin  // [RULE5]
      tx_sr_reg   <= rd_word;
      last_rd_reg <= rd_word;
      sdo_out     <= rd_word[31];
      skip_reg    <= 1'b1;
    end else if (load_crc) begin  // [RULE11]
      tx_sr_reg <= {rd_crc, 24'h0};
      sdo_out   <= rd_crc[7];
      skip_reg  <= 1'b1;
    end else if (sclk_fall) begin
      // the first falling edge after a load already shows the msb
      if (skip_reg) skip_reg <= 1'b0;
      else begin
        tx_sr_reg <= {tx_sr_reg[30:0], 1'b0};
        sdo_out   <= tx_sr_reg[30];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_ta_done;
    cs_act && sclk_rise && bit_cnt_reg == '0 && state_reg == spi_port_pkg::ST_TA;
  endsequence
  property p_read_start;
    @(posedge sys_clk) disable iff (sys_rst)
      s_ta_done |=> req.rd ##1 rd_pend_reg ##1 (sdo_out == $past(rd_word[31]));
  endproperty
  a_read_start: assert property (p_read_start) else $error("read word not presented after turnaround"); // [RULE17]
  property p_oe_read;
    @(posedge sys_clk) disable iff (sys_rst)
      sdo_oe |-> !wr_dir_reg && cs_act;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("data out driven outside a read"); // [RULE6]
  property p_hdr_crc;
    @(posedge sys_clk) disable iff (sys_rst)
      state_reg == spi_port_pkg::ST_HCRC && cs_act && sclk_rise && bit_cnt_reg == '0 &&
      in_word[7:0] != spi_port_pkg::crc8_bits(spi_port_pkg::CRC_SEED, {16'h0, hdr_now},
                                              spi_port_pkg::HDR_W)
      |=> crc_error && state_reg == spi_port_pkg::ST_DROP;
  endproperty
  a_hdr_crc: assert property (p_hdr_crc) else $error("bad header crc not refused"); // [RULE10]
  property p_data_no_crc;
    @(posedge sys_clk) disable iff (sys_rst)
      is_data_reg |-> state_reg != spi_port_pkg::ST_WCRC && state_reg != spi_port_pkg::ST_RCRC;
  endproperty
  a_data_no_crc: assert property (p_data_no_crc) else $error("frame word given a crc"); // [RULE12]
  property p_w1c;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_stat && req.data[0] && !status_event[0] |=> !stat_evt_reg[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("written one did not clear event bit"); // [RULE14]
  property p_latch_hi;
    @(posedge sys_clk) disable iff (sys_rst)
      status_level_hi ##1 !rd_stat[*2] |=> lh_reg;
  endproperty
  a_latch_hi: assert property (p_latch_hi) else $error("latched high event lost before read"); // [RULE15]
  property p_self_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      action_done && !wr_ctrl |=> !action_start;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("self clearing bit stuck"); // [RULE16]
  property p_full_word;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_txd && tx_remain_reg >= spi_port_pkg::BYTES_PER_WORD |-> req.byte_en == 4'hf;
  endproperty
  a_full_word: assert property (p_full_word) else $error("full frame word lost bytes"); // [RULE8]
  property p_strap_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      strap_done_reg |=> $stable(crc_en_reg) && $stable(generic_reg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture"); // [RULE9]
  property p_proto_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      !generic_reg |-> !sdo_oe && !req.wr && !req.rd;
  endproperty
  a_proto_idle: assert property (p_proto_idle) else $error("port active with other protocol"); // [RULE2]
endmodule

//--- verilog/spi_port_pkg.sv
// shared constants, types and the checksum function of the serial register port
// assumes one 50 MHz system clock; all link pins arrive asynchronously
package spi_port_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int WORD_W = 32;
  localparam int HDR_W  = 16;
  localparam logic [4:0] HDR_LAST  = 5'd15;
  localparam logic [4:0] CRC_LAST  = 5'd7;
  localparam logic [4:0] TA_LAST   = 5'd7;
  localparam logic [4:0] WORD_LAST = 5'd31;
  localparam int HDR_MARK1_BIT = 15;
  localparam int HDR_MARK0_BIT = 14;
  localparam int HDR_DIR_BIT   = 13;
  localparam logic HDR_MARK1 = 1'b1;
  localparam logic HDR_MARK0 = 1'b0;
  localparam logic DIR_READ  = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0004;
  // ****************************************
  // local registers inside the port
  // ****************************************
  localparam logic [12:0] ADDR_CTRL    = 13'h1f00;
  localparam logic [12:0] ADDR_STATUS  = 13'h1f01;
  localparam logic [12:0] ADDR_TX_LEN  = 13'h1f02;
  localparam logic [12:0] ADDR_TX_DATA = 13'h1f03;
  localparam logic [12:0] ADDR_RX_DATA = 13'h1f04;
  localparam int CTRL_SC_BIT = 0;
  localparam int STAT_LH_BIT = 8;
  localparam int STAT_LL_BIT = 9;
  // ****************************************
  // pin sampling
  // ****************************************
  localparam int PIN_SCLK  = 0;
  localparam int PIN_CS_N  = 1;
  localparam int PIN_SDI   = 2;
  localparam int PIN_STRAP = 3;
  localparam int PIN_PROTO = 4;
  localparam logic [4:0] PIN_RST = 5'h02;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum {ST_HDR, ST_HCRC, ST_TA, ST_WDATA, ST_WCRC, ST_RDATA, ST_RCRC, ST_DROP} link_state_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [31:0] data;
    logic [3:0]  byte_en;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // msb first over the low n bits of d
  function automatic logic [7:0] crc8_bits(input logic [7:0] seed, input logic [31:0] d,
                                           input int n);
    logic [7:0] c;
    c = seed;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      if (i < n) begin
        c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage
